// ### rtl/i2cmc_core.sv
// two-wire master/slave controller with single-byte buffer and dma bursts
`timescale 1ns/10ps
`include "i2cmc_defs.svh"
module i2cmc_core
   import i2cmc_pkg::*;
#(
   parameter int DIV_W   = `I2CMC_DIV_W,
   parameter int BURST_W = `I2CMC_BURST_W
) (
   input  wire logic                     sys_clk_i,
   input  wire logic                     reset_i,
   input  wire logic                     master_en_i,
   input  wire logic                     slave_en_i,
   input  wire logic                     addr_cmp_en_i,
   input  wire logic                     ack_en_i,
   input  wire logic [`I2CMC_ADDR_W-1:0] own_addr_i,
   input  wire logic [DIV_W-1:0]         serial_clock_divider_i,
   input  wire logic                     dma_en_i,
   input  wire logic [BURST_W-1:0]       burst_size_i,
   input  wire logic                     start_cmd_i,
   input  wire logic                     stop_cmd_i,
   input  wire logic [7:0]               tx_data_i,
   input  wire logic                     tx_load_i,
   input  wire logic                     irq_clr_i,
   input  wire logic                     dma_ack_i,
   input  wire logic                     scl_i,
   input  wire logic                     sda_i,
   output logic                          scl_o,
   output logic                          scl_oe_o,
   output logic                          sda_o,
   output logic                          sda_oe_o,
   output logic                          irq_o,
   output logic                          dma_req_o,
   output logic [7:0]                    rx_data_o,
   output i2cmc_status_s                 master_control_status_o
);

   // ==================================================================
   // bus sampling
   logic scl_s1, scl_s2, scl_d;
   logic sda_s1, sda_s2, sda_d;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d  <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d  <= 1'b1;
      end else begin
         scl_s1 <= scl_i;
         scl_s2 <= scl_s1;
         scl_d  <= scl_s2;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         sda_d  <= sda_s2;
      end
   end

   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise  = scl_s2 & ~scl_d;
   assign scl_fall  = ~scl_s2 & scl_d;
   assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;

   // ==================================================================
   // shared state and decode
   i2cmc_mst_e         mst_state_r;
   i2cmc_status_s      stat_r;
   logic [3:0]         bitcnt_r;
   logic [7:0]         sh_r;
   logic [7:0]         buf_r;
   logic [BURST_W-1:0] byte_cnt_r;
   logic first_r, rw_r, slv_sel_r, eng_drive_r, hold_r;
   logic mst_scl_low_r, mst_sda_r, stop_req_r, tick;

   logic is_mst, engaged, is_tx, addr_ok, rel, burst_end;
   logic arb_ev, nack_ev, err_ev, abort;
   logic ev_addr, ev_rx, ev_tx, ev_data;

   assign is_mst  = mst_state_r != MST_IDLE;
   assign engaged = is_mst | slv_sel_r | (first_r & slave_en_i);
   // address byte goes out only from the master; lsb is direction
   assign is_tx   = is_mst ? (first_r | ~rw_r) : (~first_r & rw_r);
   assign addr_ok = slave_en_i & ~is_mst &
                    (~addr_cmp_en_i | (sh_r[7:1] == own_addr_i));
   assign rel       = hold_r & (irq_clr_i | dma_ack_i);
   assign burst_end = ~dma_en_i | (byte_cnt_r == burst_size_i);

   // released a one but the bus reads zero: another master won
   assign arb_ev  = scl_rise & engaged & (bitcnt_r < `I2CMC_BIT_ACK) &
                    is_mst & is_tx & ~eng_drive_r & ~sda_s2;
   assign nack_ev = scl_rise & engaged & (bitcnt_r == `I2CMC_BIT_ACK) &
                    is_tx & sda_s2;
   // start or stop in the middle of a byte
   assign err_ev  = (start_det | stop_det) & engaged &
                    (bitcnt_r != `I2CMC_BIT_CNT0);
   assign abort   = is_mst & (arb_ev | err_ev);

   assign ev_addr = scl_fall & engaged & first_r & (bitcnt_r == `I2CMC_BIT_END);
   assign ev_rx   = scl_fall & engaged & ~first_r & ~is_tx &
                    (bitcnt_r == `I2CMC_BIT_ACK);
   assign ev_tx   = scl_fall & engaged & ~first_r & is_tx &
                    (bitcnt_r == `I2CMC_BIT_END);
   assign ev_data = ev_rx | ev_tx;

   // ==================================================================
   // working clock
   i2cmc_clkdiv #(
      .DIV_W (DIV_W)
   ) u_div (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .run_i     (is_mst),
      .div_i     (serial_clock_divider_i),
      .tick_o    (tick)
   );

   // ==================================================================
   // single-byte buffer
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         buf_r <= `I2CMC_BYTE_RST;
      end else if (tx_load_i) begin
         buf_r <= tx_data_i;
      end
   end

   // ==================================================================
   // master sequencer
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || abort) begin
         mst_state_r   <= MST_IDLE;
         mst_scl_low_r <= 1'b0;
         mst_sda_r     <= 1'b0;
         stop_req_r    <= 1'b0;
      end else begin
         if (stop_cmd_i && is_mst) begin
            stop_req_r <= 1'b1;
         end
         case (mst_state_r)
            MST_IDLE: begin
               stop_req_r <= 1'b0;
               if (start_cmd_i && master_en_i && !stat_r.busy) begin
                  mst_state_r <= MST_START;
                  mst_sda_r   <= 1'b1;
               end
            end
            MST_START: begin
               // tick spacing lets the start be seen before scl drops
               if (tick) begin
                  // sda stays pulled until the byte engine owns the first bit,
                  // so sda never rises in the same cycle that scl falls
                  mst_state_r   <= MST_BITS;
                  mst_scl_low_r <= 1'b1;
               end
            end
            MST_BITS: begin
               if (tick) begin
                  if (stop_req_r && mst_scl_low_r &&
                      bitcnt_r == `I2CMC_BIT_CNT0) begin
                     mst_state_r <= MST_STOP;
                     mst_sda_r   <= 1'b1;
                     stop_req_r  <= 1'b0;
                  end else if (mst_scl_low_r && !hold_r) begin
                     mst_scl_low_r <= 1'b0;
                     mst_sda_r     <= 1'b0;
                  end else if (!mst_scl_low_r && scl_s2) begin
                     // waits for scl high so a stretching slave is honoured
                     mst_scl_low_r <= 1'b1;
                  end
               end
            end
            MST_STOP: begin
               if (tick) begin
                  if (mst_scl_low_r) begin
                     mst_scl_low_r <= 1'b0;
                  end else if (scl_s2) begin
                     mst_sda_r   <= 1'b0;
                     mst_state_r <= MST_IDLE;
                  end
               end
            end
            default: begin
               mst_state_r <= MST_IDLE;
            end
         endcase
      end
   end

   // ==================================================================
   // byte engine, shared by master and slave
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || abort || stop_det) begin
         bitcnt_r    <= `I2CMC_BIT_CNT0;
         first_r     <= 1'b0;
         rw_r        <= 1'b0;
         slv_sel_r   <= 1'b0;
         eng_drive_r <= 1'b0;
         hold_r      <= 1'b0;
         byte_cnt_r  <= '0;
         sh_r        <= `I2CMC_BYTE_RST;
      end else if (start_det) begin
         bitcnt_r    <= `I2CMC_BIT_CNT0;
         first_r     <= 1'b1;
         slv_sel_r   <= 1'b0;
         eng_drive_r <= 1'b0;
         hold_r      <= 1'b0;
         byte_cnt_r  <= '0;
         if (is_mst) begin
            sh_r <= buf_r;
         end
      end else begin
         if (rel) begin
            hold_r <= 1'b0;
            if (bitcnt_r == `I2CMC_BIT_ACK) begin
               eng_drive_r <= ack_en_i;
            end else if (is_tx) begin
               sh_r        <= buf_r;
               eng_drive_r <= ~buf_r[7];
            end
         end
         if (scl_rise && engaged) begin
            if (bitcnt_r < `I2CMC_BIT_ACK) begin
               sh_r     <= {sh_r[6:0], sda_s2};
               bitcnt_r <= bitcnt_r + 4'h1;
            end else if (bitcnt_r == `I2CMC_BIT_ACK) begin
               bitcnt_r <= `I2CMC_BIT_END;
            end
         end
         if (scl_fall && engaged) begin
            if (bitcnt_r < `I2CMC_BIT_ACK) begin
               eng_drive_r <= is_tx & ~sh_r[7];
            end else if (bitcnt_r == `I2CMC_BIT_ACK) begin
               eng_drive_r <= first_r & addr_ok;
               if (!first_r && !is_tx) begin
                  hold_r <= 1'b1;
               end
            end else begin
               bitcnt_r    <= `I2CMC_BIT_CNT0;
               eng_drive_r <= 1'b0;
               first_r     <= 1'b0;
               if (first_r) begin
                  rw_r      <= sh_r[0];
                  slv_sel_r <= addr_ok;
                  hold_r    <= is_mst | addr_ok;
               end else if (is_tx) begin
                  hold_r <= 1'b1;
               end
            end
         end
         if (ev_data) begin
            byte_cnt_r <= burst_end ? '0 : byte_cnt_r + 1'b1;
         end
      end
   end

   // ==================================================================
   // receive data and dma request
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         rx_data_o <= `I2CMC_BYTE_RST;
         dma_req_o <= 1'b0;
      end else begin
         if (ev_rx) begin
            rx_data_o <= sh_r;
         end
         dma_req_o <= dma_en_i & ev_data;
      end
   end

   // ==================================================================
   // status flags; a new event beats a clear in the same cycle
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         stat_r <= '0;
      end else begin
         if (start_det) begin
            stat_r.busy <= 1'b1;
         end else if (stop_det) begin
            stat_r.busy <= 1'b0;
         end
         stat_r.tx_mode    <= engaged & is_tx;
         stat_r.byte_done  <= (stat_r.byte_done & ~irq_clr_i) | ev_data | ev_addr;
         stat_r.arb_lost   <= (stat_r.arb_lost & ~irq_clr_i) | arb_ev;
         stat_r.nack       <= (stat_r.nack & ~irq_clr_i) | nack_ev;
         stat_r.bus_err    <= (stat_r.bus_err & ~irq_clr_i) | err_ev;
         stat_r.addr_match <= (stat_r.addr_match & ~irq_clr_i) |
                              (ev_addr & addr_ok);
         stat_r.stop_seen  <= (stat_r.stop_seen & ~irq_clr_i) | stop_det;
         stat_r.xfer_done  <= (stat_r.xfer_done & ~irq_clr_i) |
                              (ev_data & burst_end) | (ev_addr & is_mst);
      end
   end

   // ==================================================================
   // pins and interrupt, all registered; pins are open drain, so the
   // output value stays low and the enable pulls the wire down
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         scl_o    <= 1'b0;
         sda_o    <= 1'b0;
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
         irq_o    <= 1'b0;
         master_control_status_o <= '0;
      end else begin
         scl_o    <= 1'b0;
         sda_o    <= 1'b0;
         scl_oe_o <= mst_scl_low_r | (~is_mst & slv_sel_r & hold_r);
         sda_oe_o <= eng_drive_r | mst_sda_r;
         irq_o    <= stat_r.bus_err | stat_r.arb_lost | stat_r.stop_seen |
                     stat_r.nack | stat_r.addr_match | stat_r.xfer_done;
         master_control_status_o <= stat_r;
      end
   end

   // ==================================================================
   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   irq_source_a: assert property (stat_r.nack |=> irq_o)
      else $error("nack flag did not raise irq");
   reset_quiet_a: assert property (@(posedge sys_clk_i) disable iff (1'b0)
      reset_i |=> !scl_oe_o && !sda_oe_o)
      else $error("pins driven after reset");
   start_cmd_a: assert property (mst_state_r == MST_IDLE ##1 mst_state_r == MST_START
      |-> $past(start_cmd_i))
      else $error("start without command");
   stop_cmd_a: assert property ($rose(mst_state_r == MST_STOP) |-> $past(stop_req_r))
      else $error("stop without command");
   arb_release_a: assert property (arb_ev |=> mst_state_r == MST_IDLE ##1 !mst_scl_low_r)
      else $error("bus kept after arbitration loss");
   err_idle_a: assert property (err_ev && is_mst |=> mst_state_r == MST_IDLE)
      else $error("master not idle after bus error");
   addr_quiet_a: assert property (!is_mst && first_r && bitcnt_r < `I2CMC_BIT_ACK
      |-> !eng_drive_r)
      else $error("slave drove address bits");
   slave_stretch_a: assert property (hold_r && slv_sel_r && !is_mst |=> scl_oe_o)
      else $error("slave released clock while holding");
   rx_irq_a: assert property (ev_rx && !dma_en_i |=> stat_r.xfer_done ##1 irq_o)
      else $error("no irq after received byte");
   ack_give_a: assert property (rel && bitcnt_r == `I2CMC_BIT_ACK && ack_en_i
      |=> eng_drive_r ##1 sda_oe_o)
      else $error("ack not driven");
   nack_flag_a: assert property (nack_ev |=> stat_r.nack)
      else $error("nack not flagged");

   start_seen_c: cover property (start_det ##[1:1000] ev_addr);
   match_seen_c: cover property (ev_addr && addr_ok);
   master_stop_c: cover property (mst_state_r == MST_STOP ##[1:600] mst_state_r == MST_IDLE);

endmodule : i2cmc_core

// ### shared/i2cmc_defs.svh
// constants for the two-wire master/slave controller
`ifndef I2CMC_DEFS_SVH
`define I2CMC_DEFS_SVH

// widths
`define I2CMC_DIV_W    8
`define I2CMC_BURST_W  4
`define I2CMC_ADDR_W   7

// bit counter landmarks within one byte (8 data clocks, then the ack clock)
`define I2CMC_BIT_ACK  4'h8
`define I2CMC_BIT_END  4'h9
`define I2CMC_BIT_CNT0 4'h0

// reset values
`define I2CMC_DIV_RST  8'h00
`define I2CMC_BYTE_RST 8'h00

`endif

// ### shared/i2cmc_pkg.sv
// types shared by the two-wire controller files
package i2cmc_pkg;

   typedef enum logic [1:0] {
      MST_IDLE  = 2'b00,
      MST_START = 2'b01,
      MST_BITS  = 2'b10,
      MST_STOP  = 2'b11
   } i2cmc_mst_e;

   // levels first, then sticky event flags cleared by irq_clr_i
   typedef struct packed {
      logic busy;
      logic tx_mode;
      logic byte_done;
      logic arb_lost;
      logic nack;
      logic bus_err;
      logic addr_match;
      logic stop_seen;
      logic xfer_done;
   } i2cmc_status_s;

endpackage : i2cmc_pkg

// ### rtl/i2cmc_clkdiv.sv
// working clock tick divided from the system clock
`timescale 1ns/10ps
`include "i2cmc_defs.svh"
module i2cmc_clkdiv
   import i2cmc_pkg::*;
#(
   parameter int DIV_W = `I2CMC_DIV_W
) (
   input  wire logic             sys_clk_i,
   input  wire logic             reset_i,
   input  wire logic             run_i,
   input  wire logic [DIV_W-1:0] div_i,
   output logic                  tick_o
);

   logic [DIV_W-1:0] cnt_r;

   // one tick every div_i+1 cycles; restarts whenever idle
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || !run_i) begin
         cnt_r  <= `I2CMC_DIV_RST;
         tick_o <= 1'b0;
      end else if (cnt_r == div_i) begin
         cnt_r  <= `I2CMC_DIV_RST;
         tick_o <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 1'b1;
         tick_o <= 1'b0;
      end
   end

endmodule : i2cmc_clkdiv

// ### bench/i2cmc_bus_model.sv
// far-side slave on the two-wire bus: acks its address, stores writes, serves reads
`timescale 1ns/10ps
module i2cmc_bus_model #(
   parameter logic [6:0] ADDR    = 7'h3c,
   parameter logic [7:0] RD_BYTE = 8'ha5
) (
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_oe_o,
   output logic [7:0]      last_o
);
   int         cnt = 10;
   logic [7:0] sh  = 8'h00;
   logic       adr = 1'b0;
   logic       act = 1'b0;
   logic       rd  = 1'b0;

   initial begin
      sda_oe_o = 1'b0;
      last_o   = 8'h00;
   end

   // ========================================
   // framing
   always @(negedge sda_i) if (scl_i === 1'b1) begin
      cnt = 0;
      adr = 1'b1;
      act = 1'b0;
   end
   always @(posedge sda_i) if (scl_i === 1'b1) begin
      act      = 1'b0;
      sda_oe_o = 1'b0;
   end
   always @(posedge scl_i) if (cnt < 9) begin
      if (cnt < 8) sh = {sh[6:0], sda_i};
      cnt = cnt + 1;
   end

   // ========================================
   // change drive only while scl is low; released line floats high on the pull-up
   always @(negedge scl_i) begin
      if (cnt == 8) begin
         if (adr) begin
            act = (sh[7:1] == ADDR);
            rd  = sh[0];
         end else if (act && !rd) last_o = sh;
         sda_oe_o = act && !(rd && !adr);
      end else if (cnt == 9) begin
         cnt      = 0;
         adr      = 1'b0;
         sda_oe_o = act && rd && !RD_BYTE[7];
      end else if (cnt < 8) begin
         sda_oe_o = act && rd && !adr && !RD_BYTE[7-cnt];
      end
   end
endmodule : i2cmc_bus_model

// ### bench/test_i2c_master_slave_controller.sv
// self-checking bench for the two-wire controller, master and slave roles
`timescale 1ns/10ps
module test_i2c_master_slave_controller;
   import i2cmc_pkg::*;
   logic          clk = 1'b0, rst = 1'b1, men = 1'b0, sen = 1'b0, cmp = 1'b1;
   logic          acken = 1'b1, dma = 1'b0, start = 1'b0, stop = 1'b0, load = 1'b0;
   logic          clr = 1'b0, dack = 1'b0, tscl = 1'b0, tsda = 1'b0, a;
   logic [6:0]    own = 7'h2b;
   logic [7:0]    div = 8'h04, txd = 8'h00, rxd, last;
   logic [3:0]    bsz = 4'h0;
   logic          scl_oe, sda_oe, msda, irq, dreq, so, sdo;
   wire           scl = !(scl_oe | tscl);
   wire           sda = !(sda_oe | tsda | msda);
   i2cmc_status_s st;
   int            bad_count = 0, check_count = 0, dreqs = 0;

   always #2.5 clk = ~clk;
   always @(posedge clk) if (dreq === 1'b1) dreqs <= dreqs + 1;

   i2cmc_core i_i2cmc_core (.sys_clk_i(clk), .reset_i(rst), .master_en_i(men),
      .slave_en_i(sen), .addr_cmp_en_i(cmp), .ack_en_i(acken), .own_addr_i(own),
      .serial_clock_divider_i(div), .dma_en_i(dma), .burst_size_i(bsz),
      .start_cmd_i(start), .stop_cmd_i(stop), .tx_data_i(txd), .tx_load_i(load),
      .irq_clr_i(clr), .dma_ack_i(dack), .scl_i(scl), .sda_i(sda), .scl_o(so),
      .scl_oe_o(scl_oe), .sda_o(sdo), .sda_oe_o(sda_oe), .irq_o(irq), .dma_req_o(dreq),
      .rx_data_o(rxd), .master_control_status_o(st));
   i2cmc_bus_model i_i2cmc_bus_model (.scl_i(scl), .sda_i(sda), .sda_oe_o(msda),
      .last_o(last));

   // ========================================
   // common tasks
   task results;
      if (bad_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task chk(input logic [8:0] got, input logic [8:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // bounded wait: 0 irq, 1 stop seen, 2 scl released
   task wait_on(input int w);
      int   i;
      logic c;
      c = 1'b0;
      for (i = 0; i < 9000 && c !== 1'b1; i++) begin
         cyc(1);
         c = (w == 0) ? irq : (w == 1) ? st.stop_seen : scl;
      end
      if (c !== 1'b1) begin
         chk(c, 9'h1);
         results();
      end
   endtask : wait_on
   task ld(input logic [7:0] d);
      txd  = d;
      load = 1'b1;
      cyc(1);
      load = 1'b0;
   endtask : ld
   task go;
      start = 1'b1;
      cyc(1);
      start = 1'b0;
   endtask : go
   task halt;
      stop = 1'b1;
      cyc(1);
      stop = 1'b0;
   endtask : halt
   task clear;
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
   endtask : clear

   // ========================================
   // bench as far-side master; waiting on scl honours clock stretching
   task m_bit(input logic b, output logic r);
      tsda = !b;
      cyc(20);
      tscl = 1'b0;
      wait_on(2);
      cyc(20);
      r    = sda;
      tscl = 1'b1;
      cyc(12);
   endtask : m_bit
   task m_byte(input logic [7:0] d);
      int   k;
      logic x;
      for (k = 7; k >= 0; k--) m_bit(d[k], x);
   endtask : m_byte
   task m_start;
      tsda = 1'b1;
      cyc(20);
      tscl = 1'b1;
      cyc(20);
   endtask : m_start
   task m_stop;
      tsda = 1'b1;
      cyc(20);
      tscl = 1'b0;
      cyc(20);
      tsda = 1'b0;
      cyc(20);
   endtask : m_stop

   // ========================================
   // main sequence
   initial begin
      cyc(3);
      rst = 1'b0;
      chk(st, 9'h000);
      chk({so, sdo, scl_oe, sda_oe, irq, dreq}, 9'h0);
      go();
      cyc(10);
      chk(sda_oe, 9'h0);
      men = 1'b1;
      chk(st.busy, 9'h0);
      ld(8'h78);
      go();
      wait_on(0);
      chk(st.xfer_done, 9'h1);
      chk(st.nack, 9'h0);
      chk({st.tx_mode, st.busy}, 9'h3);
      chk({st.byte_done, so, sdo}, 9'h4);
      ld(8'h5a);
      clear();
      wait_on(0);
      chk(last, 9'h05a);
      chk(st.nack, 9'h0);
      halt();
      wait_on(1);
      chk({scl_oe, sda_oe, irq}, 9'h1);
      clear();
      chk(st.busy, 9'h0);
      ld(8'h7e);
      go();
      wait_on(0);
      chk(st.nack, 9'h1);
      halt();
      wait_on(1);
      clear();
      ld(8'h79);
      go();
      wait_on(0);
      clear();
      wait_on(0);
      chk(rxd, 9'h0a5);
      chk(st.tx_mode, 9'h0);
      acken = 1'b0;
      halt();
      clear();
      wait_on(1);
      clear();
      acken = 1'b1;
      // slave role
      men = 1'b0;
      sen = 1'b1;
      m_start();
      m_byte(8'h56);
      m_bit(1'b1, a);
      chk(a, 9'h0);
      chk(st.addr_match, 9'h1);
      clear();
      dma = 1'b1;
      bsz = 4'h1;
      m_byte(8'hc3);
      chk({irq, scl}, 9'h0);
      chk(rxd, 9'h0c3);
      dack = 1'b1;
      cyc(1);
      dack = 1'b0;
      m_bit(1'b1, a);
      chk(a, 9'h0);
      m_byte(8'h3c);
      chk(st.xfer_done, 9'h1);
      chk(dreqs, 9'h2);
      clear();
      m_bit(1'b1, a);
      m_stop();
      chk(st.stop_seen, 9'h1);
      clear();
      dma = 1'b0;
      m_start();
      m_byte(8'h20);
      m_bit(1'b1, a);
      chk({a, irq}, 9'h2);
      m_stop();
      clear();
      cmp = 1'b0;
      m_start();
      m_byte(8'h20);
      m_bit(1'b1, a);
      chk({a, st.addr_match}, 9'h1);
      clear();
      m_stop();
      clear();
      results();
   end
endmodule : test_i2c_master_slave_controller
